// ### hw/rftx_fifo.sv
// Small valid/ready FIFO in front of the data buffer
`timescale 1ns/1ps
module rftx_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic flush,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_q [D];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0] cnt_q;
	logic push, pop;

	assign in_ready = (cnt_q != (AW+1)'(D));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rp_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge sys_clk) begin
		if (clk_en && push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else if (clk_en) begin
			if (flush) begin
				wp_q <= '0;
				rp_q <= '0;
				cnt_q <= '0;
			end else begin
				if (push) begin
					wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
				end
				if (pop) begin
					rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
				end
				cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
			end
		end
	end
endmodule

// ### hw/rftx_sync.sv
// Two-flop synchroniser for a pin level
`timescale 1ns/1ps
module rftx_sync (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	// Level
	input wire logic din,
	output logic dout
);
	logic meta_q;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= 1'b0;
			dout <= 1'b0;
		end else if (clk_en) begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule

// ### hw/rftx_top.sv
// Transmit buffer, bit serialiser and interrupt pin logic
//
// Behaviour
// - Mode bits high 0, low 1 select transmit
// - Bit rate from baud, lower limit, extend
// - Modulation select 1 is ASK, 0 FSK
// - NRZ pattern mode sends bit level directly
// - Manchester: 1 rises, 0 falls
// - Start-up with synth on until lock
// - Buffer writable in start-up and transmit
// - Auto send when active, MSB first
// - Pending count up on load, down on send
// - Interrupt at chosen level while counting down
// - Config writes in transmit flush buffer, count
// - Transparent mode modulates from serial pin
// - Interrupt pin high until cleared
// - Status changes interrupt; status read clears
// - Buffer or config write clears level interrupt
// - Receive level, error, bit check interrupt
// - Receive interrupts suppressed during buffer read
// - Sixteen-byte buffer, overflow overwrites oldest
`timescale 1ns/1ps
module rftx_top #(
	parameter int DEPTH = rftx_pkg::BUF_DEPTH
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	// Configuration
	input wire logic op_sel_high,
	input wire logic op_sel_low,
	input wire logic transparent_mode,
	input wire logic pattern_mode,
	input wire logic modulation_select,
	input wire logic range_extend_bit,
	input wire logic [5:0] lim_min,
	input wire logic [1:0] baud_range,
	input wire logic irq_level_high,
	input wire logic irq_level_low,
	input wire logic cfg_write,
	// Controller accesses
	input wire logic buf_wr_valid,
	output logic buf_wr_ready,
	input wire logic [7:0] buf_wr_data,
	input wire logic buf_reading,
	input wire logic status_read,
	input wire logic delete_irq,
	// Status and receive events
	input wire logic [1:0] state_status_bits,
	input wire logic power_on,
	input wire logic aux_power_on,
	input wire logic rx_mode,
	input wire logic rx_level_hit,
	input wire logic rx_error,
	input wire logic bit_check_ok,
	// Radio side
	input wire logic synth_lock,
	input wire logic serial_in_tx_direct,
	output logic synth_en,
	output logic rf_high,
	output logic rf_ask,
	output logic tx_active,
	// Readback and interrupt
	output logic [rftx_pkg::CNT_W-1:0] pending_count,
	output logic irq
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = rftx_pkg::CNT_W;

	rftx_pkg::rftx_state_t state_q, state_d;
	logic [7:0] buf_q [DEPTH];
	logic [AW-1:0] wp_q, rp_q;
	logic [CW-1:0] cnt_q;
	logic [7:0] shift_q;
	logic [2:0] bit_q;
	logic half_q, busy_q;
	logic [15:0] baud_q;
	logic [15:0] period;
	logic tick;
	logic tx_sel, flush, lock_s, pin_s;
	logic f_valid, f_ready;
	logic [7:0] f_data;
	logic load, take;
	logic [CW-1:0] level;
	logic [1:0] st_prev_q;
	logic pon_prev_q, aux_prev_q;
	logic stat_irq_q, tx_irq_q, rx_irq_q;
	logic stat_ev, tx_ev, rx_ev;
	logic [1:0] irq_code;

	assign tx_sel = !op_sel_high && op_sel_low && !rx_mode;
	assign flush = cfg_write && tx_sel;

	rftx_sync u_lock (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.din(synth_lock),
		.dout(lock_s)
	);

	rftx_sync u_pin (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.din(serial_in_tx_direct),
		.dout(pin_s)
	);

	// Front FIFO absorbs bursts from the serial port
	rftx_fifo #(
		.W(rftx_pkg::FIFO_W),
		.D(rftx_pkg::FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.flush(flush),
		.in_valid(buf_wr_valid),
		.in_ready(buf_wr_ready),
		.in_data(buf_wr_data),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data)
	);

	// Loads only in start-up or transmit; stalls the FIFO otherwise
	assign f_ready = (state_q != rftx_pkg::ST_IDLE) && !transparent_mode
		&& !flush;
	assign load = f_valid && f_ready;

	always_comb begin
		state_d = state_q;
		case (state_q)
			rftx_pkg::ST_IDLE: begin
				if (tx_sel) begin
					state_d = rftx_pkg::ST_START;
				end
			end
			rftx_pkg::ST_START: begin
				if (!tx_sel) begin
					state_d = rftx_pkg::ST_IDLE;
				end else if (lock_s) begin
					state_d = rftx_pkg::ST_TX;
				end
			end
			rftx_pkg::ST_TX: begin
				if (!tx_sel) begin
					state_d = rftx_pkg::ST_IDLE;
				end
			end
			default: state_d = rftx_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= rftx_pkg::ST_IDLE;
		end else if (clk_en) begin
			state_q <= state_d;
		end
	end

	// Half-bit period; extend bit doubles it for the slowest rates
	assign period = ((rftx_pkg::BAUD_BASE << baud_range) + 16'(lim_min))
		<< range_extend_bit;
	assign tick = (baud_q == '0);

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			baud_q <= '0;
		end else if (clk_en) begin
			if (tick || !busy_q) begin
				baud_q <= period;
			end else begin
				baud_q <= baud_q - 1'b1;
			end
		end
	end

	// Next byte is taken when idle or at the end of the last bit
	assign take = (state_q == rftx_pkg::ST_TX) && !transparent_mode
		&& (cnt_q != '0) && !flush
		&& (!busy_q || (tick && half_q && bit_q == '0));

	always_ff @(posedge sys_clk) begin
		if (clk_en && load) begin
			buf_q[wp_q] <= f_data;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else if (clk_en) begin
			if (flush) begin
				wp_q <= '0;
				rp_q <= '0;
				cnt_q <= '0;
			end else begin
				if (load) begin
					wp_q <= wp_q + 1'b1;
				end
				// Overflow overwrites: read pointer follows the writer
				if (take || (load && cnt_q == CW'(DEPTH))) begin
					rp_q <= rp_q + 1'b1;
				end
				if (load && !take && cnt_q != CW'(DEPTH)) begin
					cnt_q <= cnt_q + 1'b1;
				end else if (take && !load) begin
					cnt_q <= cnt_q - 1'b1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_q <= '0;
			bit_q <= '0;
			half_q <= 1'b0;
			busy_q <= 1'b0;
		end else if (clk_en) begin
			if (flush || state_q != rftx_pkg::ST_TX) begin
				busy_q <= 1'b0;
			end else if (take) begin
				shift_q <= buf_q[rp_q];
				bit_q <= rftx_pkg::BIT_MSB;
				half_q <= 1'b0;
				busy_q <= 1'b1;
			end else if (busy_q && tick) begin
				half_q <= !half_q;
				if (half_q) begin
					if (bit_q == '0) begin
						busy_q <= 1'b0;
					end else begin
						shift_q <= {shift_q[6:0], 1'b0};
						bit_q <= bit_q - 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rf_high <= 1'b0;
			rf_ask <= 1'b0;
			synth_en <= 1'b0;
			tx_active <= 1'b0;
			pending_count <= '0;
		end else if (clk_en) begin
			synth_en <= (state_d != rftx_pkg::ST_IDLE);
			tx_active <= (state_d == rftx_pkg::ST_TX);
			rf_ask <= modulation_select;
			pending_count <= cnt_q;
			if (state_q != rftx_pkg::ST_TX) begin
				rf_high <= 1'b0;
			end else if (transparent_mode) begin
				rf_high <= pin_s;
			end else if (!busy_q) begin
				rf_high <= 1'b0;
			end else if (pattern_mode) begin
				rf_high <= shift_q[7];
			end else begin
				rf_high <= shift_q[7] ~^ half_q;
			end
		end
	end

	assign irq_code = {irq_level_high, irq_level_low};
	always_comb begin
		case (irq_code)
			rftx_pkg::IRQL_12: level = rftx_pkg::LVL_12;
			rftx_pkg::IRQL_8: level = rftx_pkg::LVL_8;
			rftx_pkg::IRQL_4: level = rftx_pkg::LVL_4;
			default: level = rftx_pkg::LVL_0;
		endcase
	end

	assign stat_ev = (state_status_bits != st_prev_q)
		|| (power_on && !pon_prev_q) || (aux_power_on && !aux_prev_q);
	assign tx_ev = take && !load && !transparent_mode
		&& (cnt_q - 1'b1 == level);
	assign rx_ev = rx_mode && !buf_reading
		&& (rx_level_hit || rx_error || (bit_check_ok && !pattern_mode));

	// Set wins over a same-cycle clear so no event is lost
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_prev_q <= '0;
			pon_prev_q <= 1'b0;
			aux_prev_q <= 1'b0;
			stat_irq_q <= 1'b0;
			tx_irq_q <= 1'b0;
			rx_irq_q <= 1'b0;
			irq <= 1'b0;
		end else if (clk_en) begin
			st_prev_q <= state_status_bits;
			pon_prev_q <= power_on;
			aux_prev_q <= aux_power_on;
			if (stat_ev) begin
				stat_irq_q <= 1'b1;
			end else if (status_read || delete_irq) begin
				stat_irq_q <= 1'b0;
			end
			if (tx_ev) begin
				tx_irq_q <= 1'b1;
			end else if (load || cfg_write || delete_irq) begin
				tx_irq_q <= 1'b0;
			end
			if (rx_ev) begin
				rx_irq_q <= 1'b1;
			end else if (cfg_write || delete_irq) begin
				rx_irq_q <= 1'b0;
			end
			irq <= stat_irq_q || tx_irq_q || rx_irq_q;
		end
	end
endmodule

// ### pkg/rftx_pkg.sv
// Shared constants for the transmit buffer and interrupt block
package rftx_pkg;
	localparam int BUF_DEPTH = 16;
	localparam int CNT_W = 5;
	localparam logic [1:0] OPM_TX = 2'h1;
	localparam logic [4:0] LVL_12 = 5'h0c;
	localparam logic [4:0] LVL_8 = 5'h08;
	localparam logic [4:0] LVL_4 = 5'h04;
	localparam logic [4:0] LVL_0 = 5'h00;
	localparam logic [1:0] IRQL_12 = 2'h0;
	localparam logic [1:0] IRQL_8 = 2'h1;
	localparam logic [1:0] IRQL_4 = 2'h2;
	localparam logic [1:0] IRQL_0 = 2'h3;
	localparam int FIFO_DEPTH = 4;
	localparam int FIFO_W = 8;
	localparam logic [2:0] BIT_MSB = 3'h7;
	localparam logic [15:0] BAUD_BASE = 16'h0008;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_START = 3'b010,
		ST_TX = 3'b100
	} rftx_state_t;
endpackage

// ### tb/rftx_synth_model.sv
// Synthesiser stand-in that reports lock a while after enable
`timescale 1ns/1ps
module rftx_synth_model #(
	parameter int LOCK_CYC = 40
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Radio side
	input wire logic synth_en,
	output logic synth_lock
);
	int cnt_q;
	// Lock drops at once when disabled, as a real loop would
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 0;
			synth_lock <= 1'b0;
		end else begin
			cnt_q <= synth_en ? cnt_q + int'(cnt_q < LOCK_CYC) : 0;
			synth_lock <= synth_en && cnt_q >= LOCK_CYC;
		end
	end
endmodule

// ### tb/rftx_top_properties.sv
// Concurrent checks on the transmit buffer block ports
`timescale 1ns/1ps
module rftx_top_properties (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	// Controls
	input wire logic op_sel_high,
	input wire logic op_sel_low,
	input wire logic rx_mode,
	input wire logic transparent_mode,
	input wire logic cfg_write,
	input wire logic irq_level_high,
	input wire logic irq_level_low,
	input wire logic [1:0] state_status_bits,
	input wire logic serial_in_tx_direct,
	// Watched outputs
	input wire logic synth_en,
	input wire logic rf_high,
	input wire logic tx_active,
	input wire logic [rftx_pkg::CNT_W-1:0] pending_count,
	input wire logic irq
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);
	logic tx_sel;
	assign tx_sel = op_sel_low && !op_sel_high && !rx_mode;
	property p_sel;
		!synth_en && !tx_sel |=> !synth_en;
	endproperty
	a_sel: assert property (p_sel) else $error("synth on unselected");
	property p_gate;
		tx_active |-> synth_en;
	endproperty
	a_gate: assert property (p_gate) else $error("tx without synth");
	property p_idle;
		(!tx_active && !transparent_mode)[*2] |-> !rf_high;
	endproperty
	a_idle: assert property (p_idle) else $error("carrier when idle");
	// Two sync flops plus output flop, one spare
	property p_tmd;
		(tx_active && transparent_mode && serial_in_tx_direct)[*5] |-> rf_high;
	endproperty
	a_tmd: assert property (p_tmd) else $error("pin not followed");
	property p_cnt;
		$changed(pending_count) |-> pending_count == 5'h00 ||
			pending_count == $past(pending_count) + 5'h01 ||
			pending_count == $past(pending_count) - 5'h01;
	endproperty
	a_cnt: assert property (p_cnt) else $error("count jump");
	property p_flush;
		cfg_write && clk_en && tx_active && tx_sel |-> ##2 pending_count == 5'h00;
	endproperty
	a_flush: assert property (p_flush) else $error("no flush");
	property p_lvl;
		// A flush from one to zero is not a count-down
		tx_active && !$past(cfg_write, 2) &&
			pending_count == $past(pending_count) - 5'h01 &&
			pending_count == 5'h0c - {1'b0, irq_level_high, irq_level_low, 2'b00}
			|-> ##[0:3] irq;
	endproperty
	a_lvl: assert property (p_lvl) else $error("no level irq");
	property p_stat;
		clk_en && $changed(state_status_bits) |-> ##[1:3] irq;
	endproperty
	a_stat: assert property (p_stat) else $error("no status irq");
endmodule
bind rftx_top rftx_top_properties u_props (
	.sys_clk(sys_clk),
	.arst_n(arst_n),
	.clk_en(clk_en),
	.op_sel_high(op_sel_high),
	.op_sel_low(op_sel_low),
	.rx_mode(rx_mode),
	.transparent_mode(transparent_mode),
	.cfg_write(cfg_write),
	.irq_level_high(irq_level_high),
	.irq_level_low(irq_level_low),
	.state_status_bits(state_status_bits),
	.serial_in_tx_direct(serial_in_tx_direct),
	.synth_en(synth_en),
	.rf_high(rf_high),
	.tx_active(tx_active),
	.pending_count(pending_count),
	.irq(irq)
);

// ### tb/tb_rftx_top.sv
// Directed bench for the transmit buffer block
`timescale 1ns/1ps
module tb_rftx_top;
	// Half bit with baud range 0, lower limit 3, no extend
	localparam int HALF = rftx_pkg::BAUD_BASE + 3 + 1;
	// Same baud range and lower limit with the extend bit set
	localparam int HALF2 = (rftx_pkg::BAUD_BASE + 3) * 2 + 1;
	logic sys_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1;
	logic op_sel_high = 1'b0, op_sel_low = 1'b0, transparent_mode = 1'b0;
	logic pattern_mode = 1'b1, modulation_select = 1'b1;
	logic range_extend_bit = 1'b0, cfg_write = 1'b0;
	logic [5:0] lim_min = 6'h03;
	logic [1:0] baud_range = 2'h0, state_status_bits = 2'h0;
	logic irq_level_high = 1'b0, irq_level_low = 1'b1;
	logic buf_wr_valid = 1'b0, buf_reading = 1'b0, status_read = 1'b0;
	logic [7:0] buf_wr_data = 8'h00;
	logic delete_irq = 1'b0, power_on = 1'b0, aux_power_on = 1'b0;
	logic rx_mode = 1'b0, rx_level_hit = 1'b0, rx_error = 1'b0;
	logic bit_check_ok = 1'b0, synth_lock, serial_in_tx_direct = 1'b0;
	logic buf_wr_ready, synth_en, rf_high, rf_ask, tx_active, irq;
	logic [rftx_pkg::CNT_W-1:0] pending_count;
	int num_errors = 0, num_checks = 0;
	rftx_top u_dut (.*);
	rftx_synth_model u_synth (.*);
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic tmo(input int i, input int lim = 300);
		if (i >= lim) begin
			chk(8'h00, 8'h01);
			stop_test();
		end
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask
	// Leaves valid high so back-to-back bytes need no gap
	task automatic wr(input logic [7:0] b);
		int i;
		buf_wr_data = b;
		buf_wr_valid = 1'b1;
		for (i = 0; i < 300 && buf_wr_ready !== 1'b1; i++) cyc(1);
		tmo(i);
		cyc(1);
	endtask
	// Samples mid-half from the first rise; Manchester starts mid-bit
	task automatic txchk(input logic [7:0] b, input int k0);
		int i;
		for (i = 0; i < 300 && rf_high !== 1'b1; i++) cyc(1);
		tmo(i);
		cyc(HALF / 2);
		for (i = k0; i < 16; i++) begin
			chk(rf_high, b[7 - i / 2] ^ (k0 == 1 && i % 2 == 0));
			cyc(HALF);
		end
	endtask
	initial begin
		int n;
		cyc(6);
		arst_n = 1'b1;
		for (int i = 0; i < 4; i++) wr(i == 0 ? 8'hb2 : 8'h00);
		buf_wr_valid = 1'b0;
		chk(buf_wr_ready, 0);
		op_sel_low = 1'b1;
		cyc(3);
		chk(synth_en, 1);
		chk(tx_active, 0);
		for (int i = 0; i < 5; i++) wr(8'h00);
		buf_wr_valid = 1'b0;
		cyc(3);
		chk(pending_count, 9);
		txchk(8'hb2, 0);
		chk(rf_ask, 1);
		chk(irq, 1);
		chk(pending_count, 7);
		wr(8'h00);
		buf_wr_valid = 1'b0;
		cyc(4);
		chk(irq, 0);
		pulse(cfg_write);
		cyc(2);
		chk(pending_count, 0);
		pattern_mode = 1'b0;
		modulation_select = 1'b0;
		irq_level_high = 1'b1;
		pulse(cfg_write);
		wr(8'h96);
		buf_wr_valid = 1'b0;
		txchk(8'h96, 1);
		chk(irq, 1);
		chk(rf_ask, 0);
		pulse(delete_irq);
		cyc(3);
		chk(irq, 0);
		transparent_mode = 1'b1;
		serial_in_tx_direct = 1'b1;
		cyc(6);
		chk(rf_high, 1);
		serial_in_tx_direct = 1'b0;
		cyc(6);
		chk(rf_high, 0);
		transparent_mode = 1'b0;
		op_sel_low = 1'b0;
		cyc(3);
		chk(synth_en, 0);
		chk(tx_active, 0);
		// Overflow in start-up, then a slow rate and level 12
		op_sel_low = 1'b1;
		irq_level_high = 1'b0;
		irq_level_low = 1'b0;
		range_extend_bit = 1'b1;
		for (int i = 0; i < 17; i++) wr(8'h5a);
		buf_wr_valid = 1'b0;
		cyc(4);
		chk(pending_count, 16);
		chk(tx_active, 0);
		for (n = 0; n < 300 && rf_high !== 1'b1; n++) cyc(1);
		tmo(n);
		for (n = 0; n < 300 && rf_high === 1'b1; n++) cyc(1);
		chk(8'(n), 8'(HALF2));
		for (n = 0; n < 1500 && irq !== 1'b1; n++) cyc(1);
		tmo(n, 1500);
		chk(pending_count, 12);
		pulse(cfg_write);
		op_sel_low = 1'b0;
		range_extend_bit = 1'b0;
		cyc(3);
		chk(pending_count, 0);
		chk(irq, 0);
		// Frozen clock enable must not see the status change
		clk_en = 1'b0;
		state_status_bits = 2'h1;
		cyc(4);
		chk(irq, 0);
		clk_en = 1'b1;
		cyc(4);
		chk(irq, 1);
		pulse(status_read);
		cyc(3);
		chk(irq, 0);
		power_on = 1'b1;
		cyc(4);
		chk(irq, 1);
		pulse(delete_irq);
		cyc(3);
		chk(irq, 0);
		aux_power_on = 1'b1;
		cyc(4);
		chk(irq, 1);
		pulse(status_read);
		cyc(3);
		chk(irq, 0);
		rx_mode = 1'b1;
		pulse(rx_level_hit);
		cyc(4);
		chk(irq, 1);
		pulse(cfg_write);
		cyc(3);
		chk(irq, 0);
		pulse(bit_check_ok);
		cyc(4);
		chk(irq, 1);
		pulse(delete_irq);
		buf_reading = 1'b1;
		pulse(rx_error);
		cyc(4);
		chk(irq, 0);
		stop_test();
	end
endmodule
